//--- core/supply_supervisor.sv
`timescale 1ns/1ps
// Overview of operation
// - flag_n low while power-fail sense is below reference or in backup mode, high otherwise.
// - kick decodes as high, low or floating; only driven counts.
// - floating kick disables the watchdog entirely.
// - watchdog counter held cleared during reset or floating kick.
// - watchdog starts counting on reset release with a driven kick.
// - every kick edge restarts the watchdog; short pulses are caught.
// - kick stuck past watchdog period fires one reset pulse.
// - stuck kick gives pulses every period plus pulse width.
// - reset asserted whenever main supply is below threshold.
// - threshold variant is chosen outside; only the compare result arrives.
// - reset held for pulse time after supply rises above threshold.
// - undervoltage during a pulse restarts a full pulse after recovery.
// - reset held from supply drop until the logic loses power.
// - active-high reset output is the exact inverse of active-low.
// - in backup mode the power-fail flag is forced low.
// - selector switches with 20mV steps each way, 40mV hysteresis.
// - backup only when main below threshold and below backup.
// - backup mode disables watchdog and keeps reset asserted.
module supply_supervisor #(
	parameter int unsigned WD_CYCLES  = supervisor_pkg::WD_PERIOD_CYC,
	parameter int unsigned RST_CYCLES = supervisor_pkg::RESET_PULSE_CYC
) (
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_reset_n,
	input  wire supervisor_pkg::cmp_t i_cmp,
	input  wire supervisor_pkg::kick_t i_watchdog_kick,
	output logic                      o_reset_n,
	output logic                      o_reset,
	output logic                      o_power_fail_flag_n,
	output logic                      o_backup_select
);

	// elaboration checks on counts
	if (WD_CYCLES < 2 || RST_CYCLES < 2) begin : g_chk
		$error("watchdog and reset counts must be at least two cycles");
	end

	// two-flop synchronisers for the analog and kick inputs
	logic [3:0] cmp_meta_reg;
	logic [3:0] cmp_sync_reg;
	logic [1:0] kick_meta_reg;
	logic [1:0] kick_sync_reg;
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cmp_meta_reg  <= 4'h1;
			cmp_sync_reg  <= 4'h1;
			kick_meta_reg <= 2'h0;
			kick_sync_reg <= 2'h0;
		end else begin
			cmp_meta_reg  <= i_cmp;
			cmp_sync_reg  <= cmp_meta_reg;
			kick_meta_reg <= i_watchdog_kick;
			kick_sync_reg <= kick_meta_reg;
		end
	end

	supervisor_pkg::cmp_t  cmp;
	supervisor_pkg::kick_t kick;
	assign cmp  = cmp_sync_reg;
	assign kick = kick_sync_reg;

	// supply selector with hysteresis
	logic backup_reg;
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			backup_reg <= 1'b0;
		end else if (!cmp.supply_low) begin
			backup_reg <= 1'b0; // main healthy: always main
		end else if (cmp.batt_above_main) begin
			backup_reg <= 1'b1;
		end else if (cmp.main_above_batt) begin
			backup_reg <= 1'b0;
		end
	end
	assign o_backup_select = backup_reg;

	// power-fail flag, independent of reset logic
	logic pf_flag_n_reg;
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pf_flag_n_reg <= 1'b0;
		end else begin
			pf_flag_n_reg <= !cmp.pf_sense_low && !backup_reg;
		end
	end
	assign o_power_fail_flag_n = pf_flag_n_reg;

	// kick edge detect on the synchronised level
	logic kick_prev_reg;
	logic kick_edge;
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			kick_prev_reg <= 1'b0;
		end else begin
			kick_prev_reg <= kick.level;
		end
	end
	// any transition of a driven kick
	assign kick_edge = kick.driven && (kick.level != kick_prev_reg);

	// reset pulse state machine
	supervisor_pkg::rst_state_t state_reg;
	supervisor_pkg::rst_state_t state_next;
	logic [supervisor_pkg::CNT_W-1:0] rst_cnt_reg;
	logic [supervisor_pkg::CNT_W-1:0] wd_cnt_reg;
	logic wd_expire;
	logic hold_cond;

	assign hold_cond = cmp.supply_low || backup_reg;
	assign wd_expire = kick.driven
		&& (wd_cnt_reg == WD_CYCLES[supervisor_pkg::CNT_W-1:0] - 1'b1)
		&& !kick_edge;

	// next-state logic
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			supervisor_pkg::ST_HOLD: begin
				if (!hold_cond) begin
					state_next = supervisor_pkg::ST_PULSE;
				end
			end
			supervisor_pkg::ST_PULSE: begin
				if (hold_cond) begin
					state_next = supervisor_pkg::ST_HOLD;
				end else if (rst_cnt_reg == RST_CYCLES[supervisor_pkg::CNT_W-1:0] - 1'b1) begin
					state_next = supervisor_pkg::ST_RUN;
				end
			end
			supervisor_pkg::ST_RUN: begin
				if (hold_cond) begin
					state_next = supervisor_pkg::ST_HOLD;
				end else if (wd_expire) begin
					state_next = supervisor_pkg::ST_PULSE;
				end
			end
			default: state_next = supervisor_pkg::ST_HOLD;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= supervisor_pkg::ST_HOLD;
		end else begin
			state_reg <= state_next;
		end
	end

	// pulse width counter, restarted on every pulse entry
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_cnt_reg <= '0;
		end else if (state_reg != supervisor_pkg::ST_PULSE) begin
			rst_cnt_reg <= '0;
		end else begin
			rst_cnt_reg <= rst_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wd_cnt_reg <= '0;
		end else if (state_reg != supervisor_pkg::ST_RUN || !kick.driven) begin
			wd_cnt_reg <= '0; // cleared in reset or with floating kick
		end else if (kick_edge || wd_expire) begin
			wd_cnt_reg <= '0;
		end else begin
			wd_cnt_reg <= wd_cnt_reg + 1'b1;
		end
	end

	// reset outputs, both from one flop
	logic rst_out_n_reg;
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_out_n_reg <= 1'b0;
		end else begin
			rst_out_n_reg <= (state_next == supervisor_pkg::ST_RUN);
		end
	end
	assign o_reset_n = rst_out_n_reg;
	assign o_reset   = ~rst_out_n_reg;

	// assertion helpers
	logic run_q;
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_q <= 1'b0;
		end else begin
			run_q <= (state_reg == supervisor_pkg::ST_RUN);
		end
	end

	AST_PF_FLAG: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!backup_reg |=> (o_power_fail_flag_n == !$past(cmp.pf_sense_low)))
		else $error("power-fail flag does not follow sense");
	// floating kick never produces a timeout
	AST_FLOAT_NO_WD: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!kick.driven |=> (wd_cnt_reg == '0))
		else $error("watchdog counted while kick floating");
	AST_WD_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg != supervisor_pkg::ST_RUN) |=> (wd_cnt_reg == '0))
		else $error("watchdog counter not cleared during reset");
	// counting starts when running with driven kick
	AST_WD_START: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_RUN && kick.driven && !kick_edge && !wd_expire)
		|=> (wd_cnt_reg == $past(wd_cnt_reg) + 1'b1))
		else $error("watchdog did not count");
	AST_KICK_RESTART: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		kick_edge |=> (wd_cnt_reg == '0))
		else $error("kick edge did not restart watchdog");
	// timeout drops the reset output next cycle
	AST_WD_RESET: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_RUN && wd_expire) |=> !o_reset_n ##1 !o_reset_n)
		else $error("watchdog timeout gave no reset");
	AST_UV_RESET: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		cmp.supply_low |=> !o_reset_n)
		else $error("reset not asserted on low supply");
	// released only after a full pulse
	AST_PULSE_DONE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		$rose(run_q) |-> $past(rst_cnt_reg, 2) == RST_CYCLES[supervisor_pkg::CNT_W-1:0] - 1'b1)
		else $error("reset released before pulse end");
	AST_INVERSE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_reset == !o_reset_n)
		else $error("reset outputs not inverse");
	AST_BACKUP_FLAG: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		backup_reg |=> !o_power_fail_flag_n)
		else $error("power-fail flag high in backup");
	AST_BACKUP_COND: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!cmp.supply_low |=> !backup_reg)
		else $error("backup selected with healthy main");
	AST_BACKUP_RST: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		backup_reg |=> !o_reset_n)
		else $error("reset released in backup");

	AST_FLAG_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(!cmp.pf_sense_low && !backup_reg) |=> o_power_fail_flag_n)
		else $error("power-fail flag low with good sense");
	AST_FLAG_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		cmp.pf_sense_low |=> !o_power_fail_flag_n)
		else $error("power-fail flag high with low sense");
	AST_FLOAT_NO_PULSE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_RUN && !kick.driven && !hold_cond) |=> o_reset_n)
		else $error("watchdog reset with floating kick");
	AST_WD_BOUND: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		wd_cnt_reg < WD_CYCLES[supervisor_pkg::CNT_W-1:0])
		else $error("watchdog counter passed its period");
	AST_NO_EARLY_WD: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_RUN && !hold_cond
		&& wd_cnt_reg < WD_CYCLES[supervisor_pkg::CNT_W-1:0] - 1'b1) |=> o_reset_n)
		else $error("watchdog reset before period end");
	AST_EXPIRE_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		wd_expire |=> (wd_cnt_reg == '0))
		else $error("watchdog counter not cleared on timeout");
	AST_EDGE_RUN: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_RUN && kick_edge && !hold_cond) |=> o_reset_n)
		else $error("reset despite kick edge");
	AST_RST_BOUND: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!(rst_cnt_reg > RST_CYCLES[supervisor_pkg::CNT_W-1:0]))
		else $error("pulse counter passed its width");
	AST_PULSE_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_PULSE) |-> !o_reset_n)
		else $error("reset released during pulse");
	AST_RELEASE_PULSE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		$rose(o_reset_n) |-> $past(state_reg == supervisor_pkg::ST_PULSE))
		else $error("reset released without pulse");
	AST_ONEHOT: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		$onehot(state_reg))
		else $error("reset state not one-hot");
	AST_RUN_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_RUN) |-> o_reset_n)
		else $error("reset low while running");
	AST_HOLD_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_HOLD) |-> !o_reset_n)
		else $error("reset released while held");
	AST_HOLD_STAY: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_HOLD && hold_cond)
		|=> (state_reg == supervisor_pkg::ST_HOLD))
		else $error("hold left with supply low");
	AST_RUN_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_RUN && hold_cond)
		|=> (state_reg == supervisor_pkg::ST_HOLD))
		else $error("run kept with supply low");
	AST_HOLD_TO_PULSE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_HOLD && !hold_cond)
		|=> (state_reg == supervisor_pkg::ST_PULSE))
		else $error("no pulse after recovery");
	AST_PULSE_RESTART: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg == supervisor_pkg::ST_PULSE && hold_cond)
		|=> (state_reg == supervisor_pkg::ST_HOLD))
		else $error("pulse not restarted on brownout");
	AST_PULSE_CNT_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(state_reg != supervisor_pkg::ST_PULSE) |=> (rst_cnt_reg == '0))
		else $error("pulse counter not cleared");
	AST_BACKUP_ENTER: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(cmp.supply_low && cmp.batt_above_main) |=> backup_reg)
		else $error("backup not selected");
	AST_BACKUP_LEAVE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(cmp.main_above_batt && !cmp.batt_above_main) |=> !backup_reg)
		else $error("main not reselected");
	AST_BACKUP_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(cmp.supply_low && !cmp.batt_above_main && !cmp.main_above_batt)
		|=> (backup_reg == $past(backup_reg)))
		else $error("selector changed inside hysteresis");
	AST_BACKUP_NEEDS_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		backup_reg |-> $past(cmp.supply_low))
		else $error("backup without low supply");
	AST_BACKUP_WD: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		backup_reg |-> ##2 (wd_cnt_reg == '0))
		else $error("watchdog counting in backup");
	AST_SYNC_DELAY: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		$past(i_reset_n, 2) |-> (cmp == $past(i_cmp, 2) && kick == $past(i_watchdog_kick, 2)))
		else $error("synchroniser delay wrong");

endmodule : supply_supervisor

//--- pkg/supervisor_pkg.sv
package supervisor_pkg;

	// oscillator rate and documented intervals
	localparam int unsigned CLK_HZ            = 40_000_000;
	localparam int unsigned WD_PERIOD_MS      = 1600;
	localparam int unsigned RESET_PULSE_MS    = 200;
	localparam int unsigned KICK_MIN_NS       = 50;
	// cycle counts derived from the rate
	localparam int unsigned WD_PERIOD_CYC     = (CLK_HZ / 1000) * WD_PERIOD_MS;
	localparam int unsigned RESET_PULSE_CYC   = (CLK_HZ / 1000) * RESET_PULSE_MS;
	localparam int unsigned KICK_MIN_CYC      = (KICK_MIN_NS * 40 + 999) / 1000;
	localparam int unsigned CNT_W             = 32;

	// three-state kick decode
	typedef struct packed {
		logic driven;
		logic level;
	} kick_t;

	// raw comparator results from the analog front end
	typedef struct packed {
		logic supply_low;
		logic batt_above_main;
		logic main_above_batt;
		logic pf_sense_low;
	} cmp_t;

	// reset pulse states
	typedef enum logic [2:0] {
		ST_HOLD  = 3'h1,
		ST_PULSE = 3'h2,
		ST_RUN   = 3'h4
	} rst_state_t;

endpackage : supervisor_pkg

//--- verification/kick_processor.sv
`timescale 1ns/1ps
// supervised processor: floats, services or abandons the kick line
module kick_processor #(
	parameter int GAP = 8
) (
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_reset_n,
	input  wire logic [1:0]            i_mode,
	output supervisor_pkg::kick_t      o_kick
);
	int cnt;

	// start floating with the level low until the first clock edge
	initial begin
		cnt = 0;
		o_kick = '0;
	end

	// mode 0 floats, mode 1 services, mode 2 holds the level stuck
	always @(posedge i_ref_clk) begin
		cnt <= (cnt >= GAP - 1) ? 0 : cnt + 1;
		o_kick.driven <= (i_mode != 2'h0);
		if (i_mode == 2'h0) begin
			o_kick.level <= ~o_kick.level; // a floating line holds no level
		end else if (i_mode == 2'h1 && i_reset_n && cnt == 0) begin
			o_kick.level <= ~o_kick.level;
		end
	end
endmodule : kick_processor

//--- verification/supply_supervisor_test.sv
`timescale 1ns/1ps
module supply_supervisor_test;
	localparam int WD  = 40;
	localparam int RST = 10;

	logic                  ref_clk;
	logic                  reset_n;
	supervisor_pkg::cmp_t  cmp;
	supervisor_pkg::kick_t kick;
	logic [1:0]            mode;
	logic                  rst_out_n;
	logic                  rst_out;
	logic                  flag_n;
	logic                  backup;
	int                    num_errors = 0;
	int                    checks_done = 0;
	int                    n;
	// rows: comparator inputs, then expected {reset_n, reset, flag_n, backup}
	logic [7:0]            rows [7] = '{8'h0A, 8'h18, 8'h86, 8'hC5, 8'h85, 8'hA6, 8'h4A};

	supply_supervisor #(.WD_CYCLES(WD), .RST_CYCLES(RST)) supply_supervisor_inst (
		.i_ref_clk          (ref_clk),
		.i_reset_n          (reset_n),
		.i_cmp              (cmp),
		.i_watchdog_kick    (kick),
		.o_reset_n          (rst_out_n),
		.o_reset            (rst_out),
		.o_power_fail_flag_n(flag_n),
		.o_backup_select    (backup)
	);

	kick_processor #(.GAP(8)) kick_processor_inst (
		.i_ref_clk(ref_clk),
		.i_reset_n(rst_out_n),
		.i_mode   (mode),
		.o_kick   (kick)
	);

	// 40 MHz oscillator
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rng(input int got, input int lo, input int hi);
		checks_done++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : rng

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	// bounded wait for the reset output to reach a level, counting cycles
	task automatic wait_rst(input logic lvl, input int max, output int cyc);
		cyc = 0;
		while (rst_out_n !== lvl) begin
			@(negedge ref_clk);
			cyc++;
			if (cyc > max) begin
				num_errors++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, rst_out_n, lvl);
				tally_and_finish();
			end
		end
	endtask : wait_rst

	initial begin
		reset_n = 1'b0;
		cmp = '0;
		mode = 2'h1;
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({rst_out_n, rst_out, flag_n, backup}, 4'h4);
		@(posedge ref_clk) reset_n <= 1'b1;
		wait_rst(1'b1, RST + 8, n);
		rng(n, RST, RST + 6);
		$display("test power-up done");
		// table of comparator levels
		foreach (rows[i]) begin
			@(posedge ref_clk) cmp <= rows[i][7:4];
			repeat (2 * RST + 10) @(negedge ref_clk);
			chk({rst_out_n, rst_out, flag_n, backup}, rows[i][3:0]);
		end
		$display("test table done");
		@(posedge ref_clk) cmp <= 4'h8;
		repeat (6) @(posedge ref_clk);
		cmp <= 4'h0;
		repeat (RST / 2) @(posedge ref_clk);
		cmp <= 4'h8;
		repeat (3) @(posedge ref_clk);
		cmp <= 4'h0;
		wait_rst(1'b1, RST + 8, n);
		rng(n, RST, RST + 6);
		$display("test brownout done");
		// stuck kick gives repeated pulses
		@(posedge ref_clk) mode <= 2'h2;
		wait_rst(1'b0, WD + RST + 10, n);
		wait_rst(1'b1, RST + 8, n);
		rng(n, RST, RST + 6);
		wait_rst(1'b0, WD + 8, n);
		rng(n, WD - 2, WD + 6);
		$display("test stuck kick done");
		// floating kick never fires the watchdog
		@(posedge ref_clk) mode <= 2'h0;
		wait_rst(1'b1, RST + 8, n);
		repeat (3 * (WD + RST)) begin
			@(negedge ref_clk);
			chk({3'h0, rst_out_n}, 4'h1);
		end
		$display("test floating kick done");
		tally_and_finish();
	end
endmodule : supply_supervisor_test
